// ### src/extended_mem_alu_ops.sv
// Purpose: Executes the rotate, subtract, skip, set and swap extended ops
// Assumes: Decoder pulses op_valid for one cycle with mem_data valid
// Notes:   Results and flags are registered; skip adds a dummy slot
`timescale 1ns/1ps
`include "xalu_params.svh"
`default_nettype none
module extended_mem_alu_ops (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             op_valid,
  input  wire xalu_pkg::xalu_op_t op,
  input  wire logic [2:0]       bit_sel,
  input  wire logic [7:0]       mem_data,
  input  wire logic [7:0]       acc_in,
  input  wire logic             carry_in,
  output logic                  mem_we,
  output logic [7:0]            mem_wdata,
  output logic                  acc_we,
  output logic [7:0]            acc_wdata,
  output logic                  flags_we,
  output logic                  carry_we,
  output logic                  carry_out,
  output logic                  signed_wrap_flag,
  output logic                  zero_flag,
  output logic                  nibble_carry_flag,
  output logic                  signed_borrow_flag,
  output logic                  multi_precision_null_flag,
  output logic                  skip_taken,
  output logic                  dummy_slot
);

  typedef enum logic [1:0] {seq_idle, seq_dummy} seq_t;

  // Subtract: a - b - borrow, returns {carry(no borrow), result}
  function automatic logic [8:0] sub8(input logic [7:0] a,
                                      input logic [7:0] b,
                                      input logic       bw);
    logic [8:0] d;
    d = {1'b0, a} - {1'b0, b} - {8'h00, bw};
    sub8 = {~d[8], d[7:0]};
  endfunction

  // Rotates by one; the fill bit is the wrapped bit or the carry
  function automatic logic [7:0] rot_l(input logic [7:0] v,
                                       input logic       fill);
    rot_l = {v[6:0], fill};
  endfunction

  function automatic logic [7:0] rot_r(input logic [7:0] v,
                                       input logic       fill);
    rot_r = {fill, v[`XALU_MSB:1]};
  endfunction

  function automatic logic [7:0] nib_swap(input logic [7:0] v);
    nib_swap = {v[3:0], v[`XALU_MSB:`XALU_NIB]};
  endfunction

  logic [7:0] res;
  logic       to_mem;
  logic       to_acc;
  logic       c_next;
  logic       c_wr;
  logic       f_wr;
  logic       skip;
  logic [8:0] diff;
  logic [4:0] lo_diff;
  logic       use_bw;
  logic [7:0] bit_mask;
  logic       ov_next;
  logic       sc_next;

  always_comb begin
    use_bw   = (op == xalu_pkg::sub_borrow_to_acc) ||
               (op == xalu_pkg::sub_borrow_to_mem);
    diff     = sub8(acc_in, mem_data, use_bw & ~carry_in);
    lo_diff  = {1'b0, acc_in[3:0]} - {1'b0, mem_data[3:0]}
               - {4'h0, use_bw & ~carry_in};
    ov_next  = (acc_in[`XALU_MSB] ^ mem_data[`XALU_MSB]) &
               (acc_in[`XALU_MSB] ^ diff[`XALU_MSB]);
    sc_next  = ov_next ^ diff[`XALU_MSB];
    bit_mask = `XALU_ONE << bit_sel;
  end

  always_comb begin
    res    = mem_data;
    to_mem = 1'b0;
    to_acc = 1'b0;
    c_next = carry_in;
    c_wr   = 1'b0;
    f_wr   = 1'b0;
    skip   = 1'b0;
    case (op)
      xalu_pkg::rot_left_mem: begin
        res    = rot_l(mem_data, mem_data[`XALU_MSB]);
        to_mem = 1'b1;
      end
      xalu_pkg::rot_left_to_acc: begin
        res    = rot_l(mem_data, mem_data[`XALU_MSB]);
        to_acc = 1'b1;
      end
      xalu_pkg::rot_left_carry_mem, xalu_pkg::rot_left_carry_to_acc: begin
        res    = rot_l(mem_data, carry_in);
        c_next = mem_data[`XALU_MSB];
        c_wr   = 1'b1;
        to_mem = (op == xalu_pkg::rot_left_carry_mem);
        to_acc = (op == xalu_pkg::rot_left_carry_to_acc);
      end
      xalu_pkg::rot_right_mem: begin
        res    = rot_r(mem_data, mem_data[0]);
        to_mem = 1'b1;
      end
      xalu_pkg::rot_right_to_acc: begin
        res    = rot_r(mem_data, mem_data[0]);
        to_acc = 1'b1;
      end
      xalu_pkg::rot_right_carry_mem, xalu_pkg::rot_right_carry_to_acc: begin
        res    = rot_r(mem_data, carry_in);
        c_next = mem_data[0];
        c_wr   = 1'b1;
        to_mem = (op == xalu_pkg::rot_right_carry_mem);
        to_acc = (op == xalu_pkg::rot_right_carry_to_acc);
      end
      xalu_pkg::sub_borrow_to_acc, xalu_pkg::sub_to_acc: begin
        res    = diff[7:0];
        c_next = diff[8];
        c_wr   = 1'b1;
        f_wr   = 1'b1;
        to_acc = 1'b1;
      end
      xalu_pkg::sub_borrow_to_mem, xalu_pkg::sub_to_mem: begin
        res    = diff[7:0];
        c_next = diff[8];
        c_wr   = 1'b1;
        f_wr   = 1'b1;
        to_mem = 1'b1;
      end
      xalu_pkg::dec_skip_zero_mem: begin
        res    = mem_data - `XALU_ONE;
        to_mem = 1'b1;
        skip   = (res == `XALU_ZERO);
      end
      xalu_pkg::dec_skip_zero_acc: begin
        res    = mem_data - `XALU_ONE;
        to_acc = 1'b1;
        skip   = (res == `XALU_ZERO);
      end
      xalu_pkg::inc_skip_zero_mem: begin
        res    = mem_data + `XALU_ONE;
        to_mem = 1'b1;
        skip   = (res == `XALU_ZERO);
      end
      xalu_pkg::inc_skip_zero_acc: begin
        res    = mem_data + `XALU_ONE;
        to_acc = 1'b1;
        skip   = (res == `XALU_ZERO);
      end
      xalu_pkg::set_ones: begin
        res    = `XALU_ONES;
        to_mem = 1'b1;
      end
      xalu_pkg::set_bit: begin
        res    = mem_data | bit_mask;
        to_mem = 1'b1;
      end
      xalu_pkg::skip_if_bit_set: begin
        skip   = |(mem_data & bit_mask);
      end
      xalu_pkg::skip_if_nonzero: begin
        to_mem = 1'b1;
        skip   = (mem_data != `XALU_ZERO);
      end
      xalu_pkg::skip_if_zero: begin
        to_mem = 1'b1;
        skip   = (mem_data == `XALU_ZERO);
      end
      xalu_pkg::nibble_exchange_mem: begin
        res    = nib_swap(mem_data);
        to_mem = 1'b1;
      end
      xalu_pkg::nibble_exchange_acc: begin
        res    = nib_swap(mem_data);
        to_acc = 1'b1;
      end
      default: begin
        res = mem_data;
      end
    endcase
  end

  // Write strobes and data, one cycle after the request
  always_ff @(posedge clk) begin
    if (rst) begin
      mem_we    <= 1'b0;
      acc_we    <= 1'b0;
      mem_wdata <= `XALU_ZERO;
      acc_wdata <= `XALU_ZERO;
    end else begin
      mem_we    <= op_valid & to_mem;
      acc_we    <= op_valid & to_acc;
      mem_wdata <= res;
      acc_wdata <= res;
    end
  end

  // Flags; carry only moves for rotate-through-carry and subtract
  always_ff @(posedge clk) begin
    if (rst) begin
      carry_we                  <= 1'b0;
      carry_out                 <= 1'b0;
      flags_we                  <= 1'b0;
      signed_wrap_flag          <= 1'b0;
      zero_flag                 <= 1'b0;
      nibble_carry_flag         <= 1'b0;
      signed_borrow_flag        <= 1'b0;
      multi_precision_null_flag <= 1'b0;
    end else begin
      carry_we  <= op_valid & c_wr;
      carry_out <= c_next;
      flags_we  <= op_valid & f_wr;
      signed_wrap_flag   <= ov_next;
      zero_flag          <= (diff[7:0] == `XALU_ZERO);
      nibble_carry_flag  <= ~lo_diff[`XALU_NIB];
      signed_borrow_flag <= sc_next;
      // Chained zero follows this result only; no earlier flag comes in
      multi_precision_null_flag <= (diff[7:0] == `XALU_ZERO);
    end
  end

  // Skip sequencer: one dummy slot after a taken skip
  seq_t seq_reg;
  always_ff @(posedge clk) begin
    if (rst) begin
      seq_reg    <= seq_idle;
      skip_taken <= 1'b0;
      dummy_slot <= 1'b0;
    end else begin
      skip_taken <= op_valid & skip;
      case (seq_reg)
        seq_idle: begin
          dummy_slot <= 1'b0;
          if (op_valid && skip) begin
            seq_reg <= seq_dummy;
          end
        end
        seq_dummy: begin
          dummy_slot <= 1'b1;
          seq_reg    <= seq_idle;
        end
        default: begin
          seq_reg <= seq_idle;
        end
      endcase
    end
  end

  a_rot_left_mem: assert property (@(posedge clk) disable iff (rst)
    op_valid && op == xalu_pkg::rot_left_mem |=> mem_we && !carry_we &&
    mem_wdata == {$past(mem_data[6:0]), $past(mem_data[`XALU_MSB])})
    else $error("left rotate wrong");
  a_acc_rot_keep: assert property (@(posedge clk) disable iff (rst)
    op_valid && op == xalu_pkg::rot_right_to_acc |=> acc_we && !mem_we)
    else $error("acc rotate touched memory");
  a_rlc_carry: assert property (@(posedge clk) disable iff (rst)
    op_valid && op == xalu_pkg::rot_left_carry_mem |=> carry_we &&
    carry_out == $past(mem_data[`XALU_MSB]) &&
    mem_wdata[0] == $past(carry_in))
    else $error("left carry rotate wrong");
  a_rrc_carry: assert property (@(posedge clk) disable iff (rst)
    op_valid && op == xalu_pkg::rot_right_carry_mem |=> carry_we &&
    carry_out == $past(mem_data[0]) &&
    mem_wdata[`XALU_MSB] == $past(carry_in))
    else $error("right carry rotate wrong");
  a_sub_result: assert property (@(posedge clk) disable iff (rst)
    op_valid && op == xalu_pkg::sub_to_mem |=> mem_we && flags_we &&
    mem_wdata == 8'($past(acc_in) - $past(mem_data)))
    else $error("subtract wrong");
  a_sub_carry: assert property (@(posedge clk) disable iff (rst)
    op_valid && op == xalu_pkg::sub_to_acc |=>
    carry_out == ($past(acc_in) >= $past(mem_data)))
    else $error("subtract carry wrong");
  a_skip_dummy: assert property (@(posedge clk) disable iff (rst)
    op_valid && skip |=> ##1 dummy_slot ##1 !dummy_slot)
    else $error("dummy slot missing");
  a_set_ones: assert property (@(posedge clk) disable iff (rst)
    op_valid && op == xalu_pkg::set_ones |=> mem_we && mem_wdata == `XALU_ONES
    && !carry_we && !flags_we)
    else $error("byte set wrong");
  a_dec_skip: assert property (@(posedge clk) disable iff (rst)
    op_valid && op == xalu_pkg::dec_skip_zero_mem |=>
    skip_taken == ($past(mem_data) == `XALU_ONE))
    else $error("dec skip wrong");
  a_rot_right_mem: assert property (@(posedge clk) disable iff (rst)
    op_valid && op == xalu_pkg::rot_right_mem |=> mem_we && !carry_we &&
    mem_wdata == {$past(mem_data[0]), $past(mem_data[`XALU_MSB:1])})
    else $error("right rotate wrong");
  a_sbc_mem_dest: assert property (@(posedge clk) disable iff (rst)
    op_valid && op == xalu_pkg::sub_borrow_to_mem |=> mem_we && !acc_we &&
    flags_we && mem_wdata == 8'($past(acc_in) - $past(mem_data) -
    {7'h00, ~$past(carry_in)}))
    else $error("borrow subtract to memory wrong");
  a_sub_flags: assert property (@(posedge clk) disable iff (rst)
    op_valid && op == xalu_pkg::sub_borrow_to_acc |=> flags_we && carry_we
    && zero_flag == (acc_wdata == `XALU_ZERO) &&
    multi_precision_null_flag == zero_flag)
    else $error("subtract zero flags wrong");
  a_inc_skip: assert property (@(posedge clk) disable iff (rst)
    op_valid && op == xalu_pkg::inc_skip_zero_mem |=> mem_we && !flags_we
    && mem_wdata == 8'($past(mem_data) + `XALU_ONE) &&
    skip_taken == (mem_wdata == `XALU_ZERO))
    else $error("inc skip wrong");
  a_acc_skip_keep: assert property (@(posedge clk) disable iff (rst)
    op_valid && op inside {xalu_pkg::dec_skip_zero_acc,
    xalu_pkg::inc_skip_zero_acc} |=> acc_we && !mem_we &&
    skip_taken == (acc_wdata == `XALU_ZERO))
    else $error("acc inc or dec skip wrong");
  a_bit_set: assert property (@(posedge clk) disable iff (rst)
    op_valid && op == xalu_pkg::set_bit |=> mem_we && !carry_we && !flags_we
    && mem_wdata == ($past(mem_data) | (`XALU_ONE << $past(bit_sel))))
    else $error("bit set wrong");
  a_bit_test: assert property (@(posedge clk) disable iff (rst)
    op_valid && op == xalu_pkg::skip_if_bit_set |=> !mem_we && !acc_we &&
    skip_taken == $past(mem_data[bit_sel]))
    else $error("bit test skip wrong");
  a_nonzero_wb: assert property (@(posedge clk) disable iff (rst)
    op_valid && op == xalu_pkg::skip_if_nonzero |=> mem_we &&
    mem_wdata == $past(mem_data) && skip_taken == (mem_wdata != `XALU_ZERO))
    else $error("nonzero test wrong");
  a_zero_wb: assert property (@(posedge clk) disable iff (rst)
    op_valid && op == xalu_pkg::skip_if_zero |=> mem_we &&
    mem_wdata == $past(mem_data) && skip_taken == (mem_wdata == `XALU_ZERO))
    else $error("zero test wrong");
  a_swap_mem: assert property (@(posedge clk) disable iff (rst)
    op_valid && op == xalu_pkg::nibble_exchange_mem |=> mem_we && !flags_we
    && mem_wdata == {$past(mem_data[3:0]),
    $past(mem_data[`XALU_MSB:`XALU_NIB])})
    else $error("nibble swap wrong");
  a_swap_acc: assert property (@(posedge clk) disable iff (rst)
    op_valid && op == xalu_pkg::nibble_exchange_acc |=> acc_we && !mem_we
    && acc_wdata == {$past(mem_data[3:0]),
    $past(mem_data[`XALU_MSB:`XALU_NIB])})
    else $error("acc nibble swap wrong");

  c_skip_seen: cover property (@(posedge clk) dummy_slot);
  c_sub_neg: cover property (@(posedge clk) flags_we && !carry_out);
  c_rot_carry: cover property (@(posedge clk) carry_we && !flags_we);
  c_acc_skip: cover property (@(posedge clk) acc_we && skip_taken);
  c_test_skip: cover property (@(posedge clk) skip_taken && !mem_we && !acc_we);

endmodule
`default_nettype wire

// ### src/xalu_params.svh
// Purpose: Constants for the extended memory ALU datapath
// Assumes: 8-bit data, one core clock
// Notes:   Function
`ifndef XALU_PARAMS_SVH
`define XALU_PARAMS_SVH
`define XALU_W         8
`define XALU_MSB       7
`define XALU_NIB       4
`define XALU_ONES      8'hff
`define XALU_ZERO      8'h00
`define XALU_ONE       8'h01
`define XALU_SKIP_CYC  2'h2
`endif

// ### src/xalu_pkg.sv
// Purpose: Types for the extended memory ALU datapath
// Assumes: Constants come from xalu_params.svh
// Notes:   Opcode list is the decoder's view of this block
package xalu_pkg;
  typedef enum logic [4:0] {
    op_none,
    rot_left_mem,
    rot_left_to_acc,
    rot_left_carry_mem,
    rot_left_carry_to_acc,
    rot_right_mem,
    rot_right_to_acc,
    rot_right_carry_mem,
    rot_right_carry_to_acc,
    sub_borrow_to_acc,
    sub_borrow_to_mem,
    sub_to_acc,
    sub_to_mem,
    dec_skip_zero_mem,
    dec_skip_zero_acc,
    inc_skip_zero_mem,
    inc_skip_zero_acc,
    set_ones,
    set_bit,
    skip_if_bit_set,
    skip_if_nonzero,
    skip_if_zero,
    nibble_exchange_mem,
    nibble_exchange_acc
  } xalu_op_t;
endpackage

// ### dv/testbench.sv
// Purpose: Self-checking bench for the extended memory ALU datapath
// Assumes: One-cycle answer, dummy slot one cycle after the strobes
// Notes:   Inputs change at the falling edge, outputs read there too
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic               clk;
  logic               rst;
  logic               op_valid;
  xalu_pkg::xalu_op_t op;
  logic [2:0]         bit_sel;
  logic [7:0]         mem_data;
  logic [7:0]         acc_in;
  logic               carry_in;
  logic               mem_we;
  logic [7:0]         mem_wdata;
  logic               acc_we;
  logic [7:0]         acc_wdata;
  logic               flags_we;
  logic               carry_we;
  logic               carry_out;
  logic               ov_f;
  logic               z_f;
  logic               ac_f;
  logic               sc_f;
  logic               cz_f;
  logic               skip_taken;
  logic               dummy_slot;
  logic [4:0]         snap;
  int                 mismatches;
  int                 n_checks;

  extended_mem_alu_ops dut_u (.clk(clk), .rst(rst), .op_valid(op_valid),
    .op(op), .bit_sel(bit_sel), .mem_data(mem_data), .acc_in(acc_in),
    .carry_in(carry_in), .mem_we(mem_we), .mem_wdata(mem_wdata),
    .acc_we(acc_we), .acc_wdata(acc_wdata), .flags_we(flags_we),
    .carry_we(carry_we), .carry_out(carry_out), .signed_wrap_flag(ov_f),
    .zero_flag(z_f), .nibble_carry_flag(ac_f), .signed_borrow_flag(sc_f),
    .multi_precision_null_flag(cz_f), .skip_taken(skip_taken),
    .dummy_slot(dummy_slot));

  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end

  task automatic chk1(input string nm, input logic e, input logic g);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk8(input string nm, input logic [7:0] e,
                      input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One instruction; strobes read one cycle on, dummy slot one more
  task automatic exec(input xalu_pkg::xalu_op_t o, input logic [7:0] m,
    input logic [7:0] a, input logic c, input logic [2:0] b,
    input logic wm, input logic [7:0] em, input logic wa,
    input logic [7:0] ea, input logic wc, input logic ec, input logic sk);
    logic fw;
    fw = o inside {xalu_pkg::sub_borrow_to_acc, xalu_pkg::sub_borrow_to_mem,
                   xalu_pkg::sub_to_acc, xalu_pkg::sub_to_mem};
    @(negedge clk);
    op_valid = 1'h1;
    op = o;
    mem_data = m;
    acc_in = a;
    carry_in = c;
    bit_sel = b;
    @(negedge clk);
    op_valid = 1'h0;
    chk1("mem_we", wm, mem_we);
    if (wm) chk8("mem_wdata", em, mem_wdata);
    chk1("acc_we", wa, acc_we);
    if (wa) chk8("acc_wdata", ea, acc_wdata);
    chk1("carry_we", wc, carry_we);
    if (wc) chk1("carry_out", ec, carry_out);
    chk1("flags_we", fw, flags_we);
    chk1("skip_taken", sk, skip_taken);
    snap = {ov_f, z_f, ac_f, sc_f, cz_f};
    @(negedge clk);
    chk1("dummy_slot", sk, dummy_slot);
    chk1("mem_we_after", 1'h0, mem_we);
  endtask

  task automatic t_rot();
    logic [7:0] v;
    logic       c;
    for (int i = 0; i < 4; i++) begin
      v = i[1] ? 8'h5a : 8'h81;
      c = i[0];
      exec(xalu_pkg::rot_left_mem, v, 8'h00, c, 3'h0, 1'h1,
           {v[6:0], v[7]}, 1'h0, 8'h00, 1'h0, 1'h0, 1'h0);
      exec(xalu_pkg::rot_left_to_acc, v, 8'h00, c, 3'h0, 1'h0,
           8'h00, 1'h1, {v[6:0], v[7]}, 1'h0, 1'h0, 1'h0);
      exec(xalu_pkg::rot_left_carry_mem, v, 8'h00, c, 3'h0, 1'h1,
           {v[6:0], c}, 1'h0, 8'h00, 1'h1, v[7], 1'h0);
      exec(xalu_pkg::rot_left_carry_to_acc, v, 8'h00, c, 3'h0, 1'h0,
           8'h00, 1'h1, {v[6:0], c}, 1'h1, v[7], 1'h0);
      exec(xalu_pkg::rot_right_mem, v, 8'h00, c, 3'h0, 1'h1,
           {v[0], v[7:1]}, 1'h0, 8'h00, 1'h0, 1'h0, 1'h0);
      exec(xalu_pkg::rot_right_to_acc, v, 8'h00, c, 3'h0, 1'h0,
           8'h00, 1'h1, {v[0], v[7:1]}, 1'h0, 1'h0, 1'h0);
      exec(xalu_pkg::rot_right_carry_mem, v, 8'h00, c, 3'h0, 1'h1,
           {c, v[7:1]}, 1'h0, 8'h00, 1'h1, v[0], 1'h0);
      exec(xalu_pkg::rot_right_carry_to_acc, v, 8'h00, c, 3'h0, 1'h0,
           8'h00, 1'h1, {c, v[7:1]}, 1'h1, v[0], 1'h0);
    end
  endtask

  task automatic sub_one(input xalu_pkg::xalu_op_t o, input logic [7:0] a,
    input logic [7:0] m, input logic c, input logic brw, input logic tm);
    logic [8:0] d;
    logic [9:0] s;
    logic [4:0] n;
    logic       bw;
    bw = brw & ~c;
    d = {1'h0, a} - {1'h0, m} - {8'h00, bw};
    // Sign of the true signed difference, wide enough never to wrap
    s = {{2{a[7]}}, a} - {{2{m[7]}}, m} - {9'h000, bw};
    n = {1'h0, a[3:0]} - {1'h0, m[3:0]} - {4'h0, bw};
    exec(o, m, a, c, 3'h0, tm, d[7:0], !tm, d[7:0], 1'h1, !d[8], 1'h0);
    chk1("overflow", (a[7] ^ m[7]) & (a[7] ^ d[7]), snap[4]);
    chk1("zero", d[7:0] == 8'h00, snap[3]);
    chk1("nibble_carry", !n[4], snap[2]);
    chk1("signed_borrow", s[9], snap[1]);
    chk1("chain_zero", d[7:0] == 8'h00, snap[0]);
  endtask

  task automatic t_sub();
    logic [15:0] tbl [5];
    tbl = '{16'h0000, 16'h1001, 16'h8001, 16'h7fff, 16'h0505};
    for (int k = 0; k < 10; k++) begin
      sub_one(xalu_pkg::sub_borrow_to_acc, tbl[k/2][15:8], tbl[k/2][7:0],
              k[0], 1'h1, 1'h0);
      sub_one(xalu_pkg::sub_borrow_to_mem, tbl[k/2][15:8], tbl[k/2][7:0],
              k[0], 1'h1, 1'h1);
      sub_one(xalu_pkg::sub_to_acc, tbl[k/2][15:8], tbl[k/2][7:0],
              k[0], 1'h0, 1'h0);
      sub_one(xalu_pkg::sub_to_mem, tbl[k/2][15:8], tbl[k/2][7:0],
              k[0], 1'h0, 1'h1);
    end
  endtask

  task automatic t_skip();
    exec(xalu_pkg::dec_skip_zero_mem, 8'h01, 8'h00, 1'h0, 3'h0, 1'h1,
         8'h00, 1'h0, 8'h00, 1'h0, 1'h0, 1'h1);
    exec(xalu_pkg::dec_skip_zero_mem, 8'h00, 8'h00, 1'h0, 3'h0, 1'h1,
         8'hff, 1'h0, 8'h00, 1'h0, 1'h0, 1'h0);
    exec(xalu_pkg::inc_skip_zero_mem, 8'hff, 8'h00, 1'h1, 3'h0, 1'h1,
         8'h00, 1'h0, 8'h00, 1'h0, 1'h0, 1'h1);
    exec(xalu_pkg::inc_skip_zero_mem, 8'h7f, 8'h00, 1'h1, 3'h0, 1'h1,
         8'h80, 1'h0, 8'h00, 1'h0, 1'h0, 1'h0);
    exec(xalu_pkg::dec_skip_zero_acc, 8'h01, 8'h33, 1'h0, 3'h0, 1'h0,
         8'h00, 1'h1, 8'h00, 1'h0, 1'h0, 1'h1);
    exec(xalu_pkg::inc_skip_zero_acc, 8'h10, 8'h00, 1'h0, 3'h0, 1'h0,
         8'h00, 1'h1, 8'h11, 1'h0, 1'h0, 1'h0);
    for (int i = 0; i < 2; i++) begin
      exec(xalu_pkg::skip_if_nonzero, i[0] ? 8'h5a : 8'h00, 8'h00, 1'h0,
           3'h0, 1'h1, i[0] ? 8'h5a : 8'h00, 1'h0, 8'h00, 1'h0, 1'h0, i[0]);
      exec(xalu_pkg::skip_if_zero, i[0] ? 8'h5a : 8'h00, 8'h00, 1'h0,
           3'h0, 1'h1, i[0] ? 8'h5a : 8'h00, 1'h0, 8'h00, 1'h0, 1'h0, !i[0]);
    end
    for (int b = 0; b < 8; b++)
      exec(xalu_pkg::skip_if_bit_set, 8'h24, 8'h00, 1'h0, b[2:0], 1'h0,
           8'h00, 1'h0, 8'h00, 1'h0, 1'h0, b == 2 || b == 5);
  endtask

  // Reset inside a taken skip must drop the pending dummy slot
  task automatic t_reset();
    @(negedge clk);
    op_valid = 1'h1;
    op = xalu_pkg::inc_skip_zero_mem;
    mem_data = 8'hff;
    @(negedge clk);
    op_valid = 1'h0;
    rst = 1'h1;
    chk1("skip_taken_pre", 1'h1, skip_taken);
    @(negedge clk);
    rst = 1'h0;
    chk1("mem_we_rst", 1'h0, mem_we);
    chk1("skip_taken_rst", 1'h0, skip_taken);
    chk1("dummy_slot_rst", 1'h0, dummy_slot);
    @(negedge clk);
    chk1("dummy_slot_after_rst", 1'h0, dummy_slot);
  endtask

  task automatic t_set_swap();
    exec(xalu_pkg::set_ones, 8'h12, 8'h00, 1'h0, 3'h0, 1'h1, 8'hff,
         1'h0, 8'h00, 1'h0, 1'h0, 1'h0);
    for (int b = 0; b < 8; b++)
      exec(xalu_pkg::set_bit, 8'h42, 8'h00, 1'h1, b[2:0], 1'h1,
           8'h42 | (8'h01 << b), 1'h0, 8'h00, 1'h0, 1'h0, 1'h0);
    exec(xalu_pkg::nibble_exchange_mem, 8'h3c, 8'h00, 1'h0, 3'h0,
         1'h1, 8'hc3, 1'h0, 8'h00, 1'h0, 1'h0, 1'h0);
    exec(xalu_pkg::nibble_exchange_acc, 8'ha5, 8'h00, 1'h0, 3'h0,
         1'h0, 8'h00, 1'h1, 8'h5a, 1'h0, 1'h0, 1'h0);
    exec(xalu_pkg::op_none, 8'h00, 8'h00, 1'h0, 3'h0, 1'h0, 8'h00,
         1'h0, 8'h00, 1'h0, 1'h0, 1'h0);
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Watchdog: a hang counts as a failure instead of running forever
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    results();
  end

  initial begin
    mismatches = 0;
    n_checks = 0;
    rst = 1'h1;
    op_valid = 1'h0;
    op = xalu_pkg::op_none;
    bit_sel = 3'h0;
    mem_data = 8'h00;
    acc_in = 8'h00;
    carry_in = 1'h0;
    repeat (4) @(negedge clk);
    rst = 1'h0;
    chk1("mem_we_reset", 1'h0, mem_we);
    t_rot();
    t_sub();
    t_skip();
    t_reset();
    t_set_swap();
    results();
  end
endmodule
`default_nettype wire
